// ===== design/rst_ctrl_pkg.sv
// Constants, register map and carrier types of the reset source controller.
// Assumes a 200 MHz register clock and a 32-bit APB register bus.
package rst_ctrl_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam int PADDR_W = 12;
	localparam logic [11:0] OFF_PIN_KEY = 12'h000;
	localparam logic [11:0] OFF_FLAGS = 12'h004;
	localparam logic [11:0] OFF_THR_KEY = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00c;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h014;

	// ==========================================================
	// Key codes and reset values
	localparam logic [7:0] KEY_GPIO = 8'h55;
	localparam logic [7:0] KEY_RSTPIN = 8'haa;
	localparam logic [7:0] KEY_POR = 8'h55;
	localparam logic [7:0] THR_2V10 = 8'h55;
	localparam logic [7:0] THR_2V55 = 8'h33;
	localparam logic [7:0] THR_3V15 = 8'h99;
	localparam logic [7:0] THR_3V80 = 8'haa;
	localparam logic [3:0] FLAGS_POR = 4'h0;
	localparam logic [4:0] IRQ_POR = 5'h00;

	// ==========================================================
	// Field positions
	localparam int FLAG_WDT_KEY = 0;
	localparam int FLAG_THR_KEY = 1;
	localparam int FLAG_LOWVOLT = 2;
	localparam int FLAG_KEY_FAULT = 3;
	localparam int EV_WDT_TIMEOUT = 4;
	localparam int NUM_EV = 5;
	localparam int ST_TIMEOUT = 0;
	localparam int ST_PWRDN = 1;
	localparam int ST_PIN_RESET = 2;
	localparam int ST_THR_LSB = 4;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int KEY_FAULT_DELAY_NS = 10000;
	localparam int KEY_FAULT_CYCLES = KEY_FAULT_DELAY_NS * CLK_MHZ / 1000;
	localparam int LVR_PERSIST_NS = 120000;
	localparam int LVR_PERSIST_CYCLES =
		(LVR_PERSIST_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		THR_SEL_2V10,
		THR_SEL_2V55,
		THR_SEL_3V15,
		THR_SEL_3V80
	} thr_sel_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic sleep_idle;
		logic powerdown;
	} cpu_mode_t;

endpackage

// ===== design/reset_source_controller.sv
// Reset source controller: key registers, reset cause flags, reset pulses.
// Assumes an APB master on pclk, an asynchronous reset pin and comparator,
// and watchdog and mode signals that come from logic on pclk.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// R01 - Pin key 0x55 means general I/O, 0xaa reset pin, others are faults.
// R02 - Invalid pin key gives full reset after fault delay, sets key-fault flag.
// R03 - Every reset but sleep watchdog timeout returns pin key to 0x55.
// R04 - Reset-pin selection overrides all other sharing of that pin.
// R05 - Key-fault flag set only by pin-key fault reset; software zero clears.
// R06 - Flag register bits seven to four always read zero.
// R07 - Genuine low-supply reset sets low-voltage flag; software zero clears it.
// R08 - Low supply resets only if low lasts longer than persistence time.
// R09 - Threshold key accepts 0x55, 0x33, 0x99, 0xaa selecting four levels.
// R10 - Bad threshold key resets after fault delay and returns it to 0x55.
// R11 - Threshold key keeps its value across a genuine low-supply reset.
// R12 - Bad threshold key sets threshold-fault flag; software zero clears it.
// R13 - Low-supply reset is disabled while in power-down mode.
// R14 - Running watchdog timeout acts as low-voltage reset, setting timeout; here it also returns the threshold key to 0x55.
// R15 - Sleep watchdog timeout clears only PC and SP, sets timeout flag.
// R16 - Flags timeout/power-down: POR 0/0, run timeout 1/u, sleep 1/1.
// R17 - Power-on reset drives the full system reset to the whole device.
// R18 - External low on reset pin, when selected, resets the device.
// R19 - Key-fault delay is a parameter count of clock cycles.
module reset_source_controller #(
	parameter int KEY_FAULT_CYCLES = rst_ctrl_pkg::KEY_FAULT_CYCLES,
	parameter int LVR_PERSIST_CYCLES = rst_ctrl_pkg::LVR_PERSIST_CYCLES
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Register bus
	input wire rst_ctrl_pkg::apb_req_t apb_req,
	output rst_ctrl_pkg::apb_rsp_t apb_rsp,
	// Reset sources
	input wire logic external_reset_pin_n,
	input wire logic supply_low,
	input wire logic wdt_timeout,
	input wire logic watchdog_key_fault,
	input wire rst_ctrl_pkg::cpu_mode_t cpu_mode,
	input wire logic status_clear,
	// Reset outputs and status
	output logic sys_reset_r,
	output logic pc_sp_clear_r,
	output logic pin_is_reset_r,
	output rst_ctrl_pkg::thr_sel_t threshold_sel_r,
	output logic watchdog_timeout_flag_r,
	output logic powerdown_flag_r,
	output logic irq_r
);
	import rst_ctrl_pkg::*;

	// ==========================================================
	// Declarations
	logic pin_meta_r, pin_s_r, low_meta_r, low_s_r;
	logic [7:0] pin_key_r, thr_key_r;
	logic [3:0] flags_r;
	logic [NUM_EV-1:0] irq_stat_r, irq_mask_r, irq_ev;
	logic [1:0] fault_pend_r;
	logic [11:0] key_cnt_r;
	logic [15:0] low_cnt_r;
	logic [4:0] hold_cnt_r;
	logic pin_key_bad, thr_key_bad, thr_valid;
	thr_sel_t thr_dec;
	logic lvr_fire, pin_fire, wdt_run_fire, wdt_sleep_fire;
	logic key_fire, full_fire, access, mapped, wr_en;
	logic [31:0] rd_mux;
	logic wr_pin_key, wr_thr_key, wr_flags, wr_irq_stat, wr_irq_mask;

	// ==========================================================
	// Pin and comparator synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= 1'b1;
			pin_s_r <= 1'b1;
			low_meta_r <= 1'b0;
			low_s_r <= 1'b0;
		end else if (ce) begin
			pin_meta_r <= external_reset_pin_n;
			pin_s_r <= pin_meta_r;
			low_meta_r <= supply_low;
			low_s_r <= low_meta_r;
		end
	end

	// ==========================================================
	// Key decode
	always_comb begin
		thr_valid = 1'b1;
		thr_dec = THR_SEL_2V10;
		unique case (thr_key_r) // R09
			THR_2V10: thr_dec = THR_SEL_2V10;
			THR_2V55: thr_dec = THR_SEL_2V55;
			THR_3V15: thr_dec = THR_SEL_3V15;
			THR_3V80: thr_dec = THR_SEL_3V80;
			default: thr_valid = 1'b0;
		endcase
	end

	assign pin_key_bad = (pin_key_r != KEY_GPIO) &&
		(pin_key_r != KEY_RSTPIN); // R01
	assign thr_key_bad = !thr_valid;

	// ==========================================================
	// Reset triggers
	// Fires once, on the cycle the low level outlasts the persistence count
	assign lvr_fire = low_s_r && !cpu_mode.powerdown &&
		(low_cnt_r == 16'(LVR_PERSIST_CYCLES)); // R08 R13
	assign pin_fire = pin_is_reset_r && !pin_s_r; // R18
	assign wdt_run_fire = wdt_timeout && !cpu_mode.sleep_idle; // R14
	assign wdt_sleep_fire = wdt_timeout && cpu_mode.sleep_idle; // R15
	assign key_fire = (fault_pend_r != 2'b00) &&
		(key_cnt_r == 12'(KEY_FAULT_CYCLES - 1)); // R19
	assign full_fire = lvr_fire || pin_fire || wdt_run_fire || key_fire;

	// Low-supply persistence counter; saturates past the limit so a long
	// brown-out gives one reset, not a stream of them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_r <= 16'h0000;
		end else if (ce) begin
			if (!low_s_r || cpu_mode.powerdown) begin
				low_cnt_r <= 16'h0000; // R08 R13
			end else if (low_cnt_r <= 16'(LVR_PERSIST_CYCLES)) begin
				low_cnt_r <= low_cnt_r + 16'h0001;
			end
		end
	end

	// Key-fault delay: a fault is latched when seen, so a later rewrite of
	// the key cannot cancel the pending reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_pend_r <= 2'b00;
			key_cnt_r <= 12'h000;
		end else if (ce) begin
			if (key_fire) begin
				fault_pend_r <= 2'b00;
				key_cnt_r <= 12'h000;
			end else begin
				fault_pend_r <= fault_pend_r |
					{thr_key_bad, pin_key_bad}; // R02 R10
				if (fault_pend_r != 2'b00) begin
					key_cnt_r <= key_cnt_r + 12'h001; // R19
				end
			end
		end
	end

	// ==========================================================
	// Reset pulse generation
	// The counter starts loaded so the whole device sees reset after POR
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_r <= RESET_HOLD_CYCLES; // R17
			sys_reset_r <= 1'b1; // R17
		end else if (ce) begin
			if (full_fire) begin
				hold_cnt_r <= RESET_HOLD_CYCLES; // R02 R14 R18
				sys_reset_r <= 1'b1;
			end else if (hold_cnt_r != 5'h00) begin
				hold_cnt_r <= hold_cnt_r - 5'h01;
				sys_reset_r <= (hold_cnt_r != 5'h01);
			end else begin
				sys_reset_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_sp_clear_r <= 1'b0;
		end else if (ce) begin
			pc_sp_clear_r <= wdt_sleep_fire && !full_fire; // R15
		end
	end

	// ==========================================================
	// APB slave: one wait state, then pready for one cycle
	assign access = apb_req.psel && apb_req.penable;
	assign mapped = (apb_req.paddr == OFF_PIN_KEY) ||
		(apb_req.paddr == OFF_FLAGS) || (apb_req.paddr == OFF_THR_KEY) ||
		(apb_req.paddr == OFF_STATUS) || (apb_req.paddr == OFF_IRQ_STAT) ||
		(apb_req.paddr == OFF_IRQ_MASK);
	assign wr_en = access && apb_rsp.pready && apb_req.pwrite && mapped;
	assign wr_pin_key = wr_en && (apb_req.paddr == OFF_PIN_KEY);
	assign wr_thr_key = wr_en && (apb_req.paddr == OFF_THR_KEY);
	assign wr_flags = wr_en && (apb_req.paddr == OFF_FLAGS);
	assign wr_irq_stat = wr_en && (apb_req.paddr == OFF_IRQ_STAT);
	assign wr_irq_mask = wr_en && (apb_req.paddr == OFF_IRQ_MASK);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (apb_req.paddr)
			OFF_PIN_KEY: rd_mux[7:0] = pin_key_r;
			OFF_FLAGS: rd_mux[3:0] = flags_r; // R06
			OFF_THR_KEY: rd_mux[7:0] = thr_key_r;
			OFF_STATUS: begin
				rd_mux[ST_TIMEOUT] = watchdog_timeout_flag_r;
				rd_mux[ST_PWRDN] = powerdown_flag_r;
				rd_mux[ST_PIN_RESET] = pin_is_reset_r;
				rd_mux[ST_THR_LSB +: 2] = threshold_sel_r;
			end
			OFF_IRQ_STAT: rd_mux[NUM_EV-1:0] = irq_stat_r;
			OFF_IRQ_MASK: rd_mux[NUM_EV-1:0] = irq_mask_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else if (ce) begin
			if (access && !apb_rsp.pready) begin
				apb_rsp.pready <= 1'b1;
				apb_rsp.pslverr <= !mapped;
				apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
			end else begin
				apb_rsp.pready <= 1'b0;
				apb_rsp.pslverr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Key registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_key_r <= KEY_POR;
		end else if (ce) begin
			if (full_fire) begin
				pin_key_r <= KEY_POR; // R03
			end else if (wr_pin_key) begin
				pin_key_r <= apb_req.pwdata[7:0];
			end
		end
	end

	// Kept over a genuine low-supply reset and a sleep watchdog timeout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_key_r <= KEY_POR;
		end else if (ce) begin
			if ((key_fire && fault_pend_r[1]) || pin_fire || wdt_run_fire ||
				(key_fire && fault_pend_r[0])) begin
				thr_key_r <= KEY_POR; // R10
			end else if (lvr_fire) begin
				thr_key_r <= thr_key_r; // R11
			end else if (wr_thr_key) begin
				thr_key_r <= apb_req.pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_is_reset_r <= 1'b0;
			threshold_sel_r <= THR_SEL_2V10;
		end else if (ce) begin
			pin_is_reset_r <= (pin_key_r == KEY_RSTPIN); // R04
			if (thr_valid) begin
				threshold_sel_r <= thr_dec; // R09
			end
		end
	end

	// ==========================================================
	// Reset cause flags: a set in the same cycle as a clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= FLAGS_POR;
		end else if (ce) begin
			flags_r <= (wr_flags ? (flags_r & apb_req.pwdata[3:0]) : flags_r) |
				{key_fire && fault_pend_r[0], // R05
				lvr_fire, // R07
				key_fire && fault_pend_r[1], // R12
				watchdog_key_fault};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_timeout_flag_r <= 1'b0; // R16
			powerdown_flag_r <= 1'b0;
		end else if (ce) begin
			if (wdt_timeout) begin
				watchdog_timeout_flag_r <= 1'b1; // R14 R16
			end else if (status_clear) begin
				watchdog_timeout_flag_r <= 1'b0;
			end
			if (wdt_sleep_fire) begin
				powerdown_flag_r <= 1'b1; // R16
			end else if (status_clear) begin
				powerdown_flag_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interrupts
	assign irq_ev = {wdt_timeout, key_fire && fault_pend_r[0], lvr_fire,
		key_fire && fault_pend_r[1], watchdog_key_fault};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= IRQ_POR;
			irq_mask_r <= IRQ_POR;
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_stat_r <= (wr_irq_stat ?
				(irq_stat_r & ~apb_req.pwdata[NUM_EV-1:0]) : irq_stat_r) |
				irq_ev;
			if (wr_irq_mask) begin
				irq_mask_r <= apb_req.pwdata[NUM_EV-1:0];
			end
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_FLAGS_UPPER_ZERO: assert property ( // R06
		apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == OFF_FLAGS
		|-> apb_rsp.prdata[31:4] == 28'h0)
		else $error("flag register upper bits not zero");

	AST_PIN_KEY_RESTORE: assert property ( // R03
		ce && full_fire |=> pin_key_r == KEY_POR && sys_reset_r)
		else $error("pin key not restored on full reset");

	AST_SLEEP_KEEPS_KEY: assert property ( // R15
		ce && wdt_sleep_fire && !full_fire && !wr_pin_key
		|=> pin_key_r == $past(pin_key_r) && pc_sp_clear_r)
		else $error("sleep timeout disturbed pin key");

	AST_KEY_FAULT_FLAG: assert property ( // R02
		ce && key_fire && fault_pend_r[0]
		|=> flags_r[FLAG_KEY_FAULT] && sys_reset_r)
		else $error("pin key fault did not reset and flag");

	AST_KEY_FLAG_STICKY: assert property ( // R05
		flags_r[FLAG_KEY_FAULT] && !wr_flags |=> flags_r[FLAG_KEY_FAULT])
		else $error("key fault flag lost without software clear");

	AST_LVR_FLAG: assert property ( // R07
		ce && lvr_fire |=> flags_r[FLAG_LOWVOLT] ##1 sys_reset_r[*4])
		else $error("low supply reset not flagged or too short");

	AST_LVR_PD_OFF: assert property ( // R13
		$past(cpu_mode.powerdown && ce) |-> low_cnt_r == 16'h0000 && !lvr_fire)
		else $error("low supply reset while powered down");

	AST_LVR_NEEDS_PERSIST: assert property ( // R08
		lvr_fire |-> $past(low_s_r) && low_cnt_r != 16'h0000)
		else $error("low supply reset without persistence");

	AST_THR_KEEP: assert property ( // R11
		ce && lvr_fire && !key_fire && !pin_fire && !wdt_run_fire
		|=> thr_key_r == $past(thr_key_r))
		else $error("threshold key changed by low supply reset");

	AST_THR_FAULT: assert property ( // R10
		ce && key_fire && fault_pend_r[1]
		|=> thr_key_r == KEY_POR && flags_r[FLAG_THR_KEY])
		else $error("threshold fault not handled");

	AST_WDT_SLEEP_FLAGS: assert property ( // R16
		ce && wdt_sleep_fire |=> watchdog_timeout_flag_r && powerdown_flag_r)
		else $error("sleep timeout flags wrong");

	AST_WDT_RUN_PD: assert property ( // R14
		ce && wdt_run_fire && !status_clear
		|=> watchdog_timeout_flag_r && powerdown_flag_r == $past(powerdown_flag_r))
		else $error("run timeout flags wrong");

	COV_LVR: cover property (ce && lvr_fire);
	COV_KEY_FAULT: cover property (ce && key_fire);
	COV_WDT_SLEEP: cover property (ce && wdt_sleep_fire);
	COV_PIN_RESET: cover property (ce && pin_fire);

endmodule // reset_source_controller

// ===== verif/supply_pin_model.sv
// Far-side model: external reset pin with pull-up and supply comparator.
// Assumes the bench sets hold and dip levels just after pclk rising edges.
`timescale 1ns/1ps
module supply_pin_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench commands
	input wire logic pin_hold,
	input wire logic supply_dip,
	// Lines into the block
	output logic external_reset_pin_n,
	output logic supply_low
);
	// ==========================================================
	// Line drivers
	// Released pin rests at the pull-up level, never at a stale value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			external_reset_pin_n <= 1'b1;
			supply_low <= 1'b0;
		end else begin
			external_reset_pin_n <= !pin_hold;
			supply_low <= supply_dip;
		end
	end
endmodule // supply_pin_model

// ===== verif/tb_top.sv
// Self-checking bench of the reset source controller over APB.
// Assumes the package constants and short fault and persistence counts.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; \
	if ((gt) !== (ex)) begin bad_count++; \
	$display("Error %s exp %h got %h", nm, ex, gt); end end
module tb_top;
	import rst_ctrl_pkg::*;
	localparam int KF = 8;
	localparam int LP = 10;
	logic pclk, presetn, pin_hold, supply_dip;
	logic external_reset_pin_n, supply_low;
	logic sys_reset_r, pc_sp_clear_r, pin_is_reset_r, irq_r;
	logic watchdog_timeout_flag_r, powerdown_flag_r;
	logic [2:0] ev;
	logic [31:0] rd;
	logic err, ce;
	thr_sel_t threshold_sel_r;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	cpu_mode_t cpu_mode;
	int bad_count, samples_checked, n;
	// ==========================================================
	// Instances
	reset_source_controller #(.KEY_FAULT_CYCLES(KF),
		.LVR_PERSIST_CYCLES(LP)) dut_u (.pclk(pclk), .presetn(presetn),
		.ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.external_reset_pin_n(external_reset_pin_n),
		.supply_low(supply_low), .wdt_timeout(ev[0]),
		.watchdog_key_fault(ev[1]), .cpu_mode(cpu_mode),
		.status_clear(ev[2]), .sys_reset_r(sys_reset_r),
		.pc_sp_clear_r(pc_sp_clear_r), .pin_is_reset_r(pin_is_reset_r),
		.threshold_sel_r(threshold_sel_r),
		.watchdog_timeout_flag_r(watchdog_timeout_flag_r),
		.powerdown_flag_r(powerdown_flag_r), .irq_r(irq_r));
	supply_pin_model part_u (.pclk(pclk), .presetn(presetn),
		.pin_hold(pin_hold), .supply_dip(supply_dip),
		.external_reset_pin_n(external_reset_pin_n),
		.supply_low(supply_low));
	// ==========================================================
	// Shared tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic hang(input string nm);
		bad_count++;
		$display("Error %s exp done got timeout", nm);
		tally_and_finish();
	endtask
	// Master holds the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 50);
		if (k >= 50) hang("pready");
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask
	task automatic wait_rst(input string nm, input logic lv);
		n = 0;
		while (sys_reset_r !== lv) begin
			@(posedge pclk);
			n++;
			if (n > 400) hang(nm);
		end
	endtask
	task automatic pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev <= 3'h0;
	endtask
	task automatic quiet(input string nm, input int c);
		int hits;
		hits = 0;
		repeat (c) begin
			@(posedge pclk);
			if (sys_reset_r === 1'b1) hits++;
		end
		`CHK(nm, 0, hits)
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_por();
		rdc("pin_key", OFF_PIN_KEY, 32'h55);
		rdc("flags", OFF_FLAGS, 32'h0);
		rdc("thr_key", OFF_THR_KEY, 32'h55);
		`CHK("to_pdf", 2'b00, {watchdog_timeout_flag_r, powerdown_flag_r})
		apb(1'b0, 12'h018, 32'h0);
		`CHK("unmapped_err", 1'b1, err)
		$display("test por done");
	endtask
	// Watchdog key event needs no reset, so it carries the interrupt test
	task automatic t_irq();
		apb(1'b1, OFF_IRQ_MASK, 32'h0);
		pulse(1);
		repeat (3) @(posedge pclk);
		`CHK("irq_masked", 1'b0, irq_r)
		apb(1'b1, OFF_IRQ_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		`CHK("irq_on", 1'b1, irq_r)
		apb(1'b1, OFF_IRQ_STAT, 32'h1);
		repeat (3) @(posedge pclk);
		`CHK("irq_off", 1'b0, irq_r)
		rdc("flags_wdk", OFF_FLAGS, 32'h1);
		apb(1'b1, OFF_FLAGS, 32'h0);
		$display("test irq done");
	endtask
	task automatic t_pin_fault();
		apb(1'b1, OFF_PIN_KEY, 32'h12);
		// Enable low must freeze the fault delay, so no reset may come early
		ce <= 1'b0;
		repeat (20) @(posedge pclk);
		ce <= 1'b1;
		wait_rst("kf_fire", 1'b1);
		`CHK("kf_delay", 1'b1, n >= KF && n <= KF + 4)
		wait_rst("kf_end", 1'b0);
		rdc("flags_kf", OFF_FLAGS, 32'h8);
		rdc("pin_key_kf", OFF_PIN_KEY, 32'h55);
		apb(1'b1, OFF_FLAGS, 32'h0);
		rdc("flags_clr", OFF_FLAGS, 32'h0);
		$display("test pin key fault done");
	endtask
	task automatic t_pin_reset();
		apb(1'b1, OFF_PIN_KEY, 32'haa);
		repeat (2) @(posedge pclk);
		`CHK("pin_reset_sel", 1'b1, pin_is_reset_r)
		pin_hold <= 1'b1;
		wait_rst("pin_fire", 1'b1);
		`CHK("pin_lat", 1'b1, n <= 5)
		repeat (5) @(posedge pclk);
		pin_hold <= 1'b0;
		wait_rst("pin_end", 1'b0);
		rdc("pin_key_res", OFF_PIN_KEY, 32'h55);
		`CHK("pin_gpio", 1'b0, pin_is_reset_r)
		rdc("flags_res", OFF_FLAGS, 32'h0);
		$display("test pin reset done");
	endtask
	task automatic t_thr();
		logic [7:0] codes [4];
		codes = '{THR_2V10, THR_2V55, THR_3V15, THR_3V80};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFF_THR_KEY, {24'h0, codes[i]});
			repeat (2) @(posedge pclk);
			`CHK("thr_sel", thr_sel_t'(i), threshold_sel_r)
		end
		apb(1'b1, OFF_THR_KEY, 32'h0);
		wait_rst("thr_fire", 1'b1);
		wait_rst("thr_end", 1'b0);
		rdc("thr_key_bad", OFF_THR_KEY, 32'h55);
		rdc("flags_thr", OFF_FLAGS, 32'h2);
		apb(1'b1, OFF_FLAGS, 32'h0);
		$display("test threshold keys done");
	endtask
	task automatic t_wdt();
		apb(1'b1, OFF_PIN_KEY, 32'haa);
		cpu_mode.sleep_idle <= 1'b1;
		pulse(0);
		n = 0;
		repeat (6) begin
			@(posedge pclk);
			n += (pc_sp_clear_r === 1'b1) + 10 * (sys_reset_r === 1'b1);
		end
		`CHK("warm_only", 1, n)
		`CHK("to_pdf_slp", 2'b11, {watchdog_timeout_flag_r, powerdown_flag_r})
		rdc("pin_key_slp", OFF_PIN_KEY, 32'haa);
		rdc("status_slp", OFF_STATUS, 32'h7);
		rdc("irq_stat", OFF_IRQ_STAT, 32'h1a);
		cpu_mode.sleep_idle <= 1'b0;
		pulse(0);
		wait_rst("wdt_fire", 1'b1);
		`CHK("wdt_lat", 1'b1, n <= 3)
		wait_rst("wdt_end", 1'b0);
		`CHK("to_pdf_run", 2'b11, {watchdog_timeout_flag_r, powerdown_flag_r})
		rdc("pin_key_wdt", OFF_PIN_KEY, 32'h55);
		$display("test watchdog done");
	endtask
	task automatic t_lowv();
		apb(1'b1, OFF_THR_KEY, 32'h99);
		supply_dip <= 1'b1;
		repeat (LP - 4) @(posedge pclk);
		supply_dip <= 1'b0;
		quiet("short_dip", 40);
		supply_dip <= 1'b1;
		wait_rst("lv_fire", 1'b1);
		supply_dip <= 1'b0;
		`CHK("lv_persist", 1'b1, n > LP)
		wait_rst("lv_end", 1'b0);
		rdc("flags_lv", OFF_FLAGS, 32'h4);
		rdc("thr_key_lv", OFF_THR_KEY, 32'h99);
		`CHK("to_pdf_lv", 2'b11, {watchdog_timeout_flag_r, powerdown_flag_r})
		apb(1'b1, OFF_FLAGS, 32'h0);
		rdc("flags_lv_clr", OFF_FLAGS, 32'h0);
		cpu_mode.powerdown <= 1'b1;
		supply_dip <= 1'b1;
		quiet("pd_dip", LP + 30);
		supply_dip <= 1'b0;
		cpu_mode.powerdown <= 1'b0;
		pulse(2);
		repeat (2) @(posedge pclk);
		`CHK("to_pdf_clr", 2'b00, {watchdog_timeout_flag_r, powerdown_flag_r})
		$display("test low supply done");
	endtask
	// ==========================================================
	// Clock and main sequence
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = !pclk;
	end
	initial begin
		presetn = 1'b0;
		pin_hold = 1'b0;
		supply_dip = 1'b0;
		ev = 3'h0;
		ce = 1'b1;
		apb_req = '0;
		cpu_mode = '0;
		bad_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_rst("por_end", 1'b0);
		`CHK("por_hold", 1'b1, n >= 16)
		t_por();
		t_irq();
		t_pin_fault();
		t_pin_reset();
		t_thr();
		t_wdt();
		t_lowv();
		tally_and_finish();
	end
endmodule // tb_top
